/* include/sync_proc_map.vh */
// register map, field positions, reset values and timing constants for the sync control block
// assumes one 25 MHz core clock; included by bare name from the design file
`ifndef SYNC_PROC_MAP_VH
`define SYNC_PROC_MAP_VH

// register addresses
`define ADDR_SYNC_MODE 8'h0E
`define ADDR_SLICER_CLAMP 8'h10
`define ADDR_SEP_THRESH 8'h11
`define ADDR_COAST_LEAD 8'h12
`define ADDR_COAST_TRAIL 8'h13
`define ADDR_SYNC_STATUS 8'h14

// reset values
`define RST_SYNC_MODE 8'h00
`define RST_SLICER_CLAMP 8'h78
`define RST_SEP_THRESH 8'h20
`define RST_COAST_LEAD 8'h00
`define RST_COAST_TRAIL 8'h00

// sync mode fields
`define MODE_H_OVERRIDE 4
`define MODE_H_SELECT 3
`define MODE_V_OVERRIDE 1
`define MODE_V_SELECT 0
`define MODE_USED_MASK 8'h1B

// slicer and clamp fields
`define SLICER_HI 7
`define SLICER_LO 3
`define RED_CLAMP_BIT 2
`define BLUE_CLAMP_BIT 1
`define SLICER_CLAMP_MASK 8'hFE

// timing
`define CLK_MHZ 25
`define CLK_NS 40
`define SEP_TICK_NS 200
`define SEP_DIV (`SEP_TICK_NS / `CLK_NS)
`define SEP_DIV_W 3
`define ACT_TIMEOUT_US 20000
`define ACT_CNT_W 20
`define LEN_W 16
`define LINE_W 12

`endif

/* src/sync_processing_control.v */
// sync processing control: registers, activity and polarity detect, source select,
// sync separator and coast window stretching
// assumes all pin inputs are synchronous to core_clk_in; register port sits behind the serial port
`include "sync_proc_map.vh"

// ----------------------------------------
// activity detector
// ----------------------------------------
module activity_detect #(
   parameter [`ACT_CNT_W-1:0] TO_CYCLES = 20'h7A120
) (
   // clock and reset
   input wire core_clk_in,
   input wire rstn_in,
   // watched level
   input wire sig_in,
   // result
   output reg active_out
);
   reg prev;
   reg [`ACT_CNT_W-1:0] idle;

   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         // start from the pin level so a static input shows no edge after reset
         prev <= sig_in;
         idle <= {`ACT_CNT_W{1'b0}};
         active_out <= 1'b0;
      end else begin
         prev <= sig_in;
         if (sig_in != prev) begin
            idle <= {`ACT_CNT_W{1'b0}};
            active_out <= 1'b1;
         end else if (idle >= TO_CYCLES - 1'b1) begin
            active_out <= 1'b0;
         end else begin
            idle <= idle + 1'b1;
         end
      end
   end
endmodule // activity_detect

module sync_processing_control #(
   parameter [`ACT_CNT_W-1:0] ACT_TIMEOUT_CYCLES = `ACT_TIMEOUT_US * `CLK_MHZ
) (
   // clock and reset
   input wire core_clk_in,
   input wire rstn_in,
   // register port
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   output reg [7:0] reg_rdata_out,
   // sync inputs
   input wire hsync_in,
   input wire vsync_in,
   input wire sync_on_green_input_in,
   // analog controls
   output wire [4:0] slicer_code_out,
   output wire red_clamp_mid_out,
   output wire blue_clamp_mid_out,
   // sync results
   output reg active_horizontal_source_out,
   output reg active_vertical_source_out,
   output reg sep_vsync_out,
   output reg coast_out
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] sync_mode;
   reg [7:0] slicer_and_clamp_config;
   reg [7:0] separator_threshold;
   reg [7:0] coast_lead_lines;
   reg [7:0] coast_trail_lines;
   wire [7:0] sync_detect_status;

   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         sync_mode <= `RST_SYNC_MODE;
         slicer_and_clamp_config <= `RST_SLICER_CLAMP;
         separator_threshold <= `RST_SEP_THRESH;
         coast_lead_lines <= `RST_COAST_LEAD;
         coast_trail_lines <= `RST_COAST_TRAIL;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `ADDR_SYNC_MODE: sync_mode <= reg_wdata_in & `MODE_USED_MASK;
            `ADDR_SLICER_CLAMP: slicer_and_clamp_config <= reg_wdata_in & `SLICER_CLAMP_MASK;
            `ADDR_SEP_THRESH: separator_threshold <= reg_wdata_in;
            `ADDR_COAST_LEAD: coast_lead_lines <= reg_wdata_in;
            `ADDR_COAST_TRAIL: coast_trail_lines <= reg_wdata_in;
            default: sync_mode <= sync_mode;
         endcase
      end
   end

   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         case (reg_addr_in)
            `ADDR_SYNC_MODE: reg_rdata_out <= sync_mode;
            `ADDR_SLICER_CLAMP: reg_rdata_out <= slicer_and_clamp_config;
            `ADDR_SEP_THRESH: reg_rdata_out <= separator_threshold;
            `ADDR_COAST_LEAD: reg_rdata_out <= coast_lead_lines;
            `ADDR_COAST_TRAIL: reg_rdata_out <= coast_trail_lines;
            `ADDR_SYNC_STATUS: reg_rdata_out <= sync_detect_status;
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end

   assign slicer_code_out = slicer_and_clamp_config[`SLICER_HI:`SLICER_LO];
   assign red_clamp_mid_out = slicer_and_clamp_config[`RED_CLAMP_BIT];
   assign blue_clamp_mid_out = slicer_and_clamp_config[`BLUE_CLAMP_BIT];

   // ----------------------------------------
   // activity and polarity detection
   // ----------------------------------------
   wire hs_active;
   wire vs_active;
   wire sog_active;
   reg hs_polarity;
   reg hs_prev;
   reg [`LEN_W-1:0] hs_hi_cnt;
   reg [`LEN_W-1:0] hs_lo_cnt;
   reg [`LEN_W-1:0] hs_hi_len;
   reg [`LEN_W-1:0] hs_lo_len;

   activity_detect #(.TO_CYCLES(ACT_TIMEOUT_CYCLES)) u_hs_act (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .sig_in(hsync_in),
      .active_out(hs_active)
   );
   activity_detect #(.TO_CYCLES(ACT_TIMEOUT_CYCLES)) u_vs_act (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .sig_in(vsync_in),
      .active_out(vs_active)
   );
   activity_detect #(.TO_CYCLES(ACT_TIMEOUT_CYCLES)) u_sog_act (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .sig_in(sync_on_green_input_in),
      .active_out(sog_active)
   );

   // the shorter phase is the pulse: a short high phase means positive-going
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         hs_prev <= 1'b0;
         hs_hi_cnt <= {`LEN_W{1'b0}};
         hs_lo_cnt <= {`LEN_W{1'b0}};
         hs_hi_len <= {`LEN_W{1'b0}};
         hs_lo_len <= {`LEN_W{1'b0}};
         hs_polarity <= 1'b0;
      end else begin
         hs_prev <= hsync_in;
         if (hsync_in && !hs_prev) begin
            hs_lo_len <= hs_lo_cnt;
            hs_lo_cnt <= {`LEN_W{1'b0}};
         end else if (!hsync_in && hs_prev) begin
            hs_hi_len <= hs_hi_cnt;
            hs_hi_cnt <= {`LEN_W{1'b0}};
         end else if (hsync_in && hs_hi_cnt != {`LEN_W{1'b1}}) begin
            hs_hi_cnt <= hs_hi_cnt + 1'b1;
         end else if (!hsync_in && hs_lo_cnt != {`LEN_W{1'b1}}) begin
            hs_lo_cnt <= hs_lo_cnt + 1'b1;
         end
         hs_polarity <= (hs_hi_len < hs_lo_len);
      end
   end

   assign sync_detect_status = {hs_active, active_horizontal_source_out, hs_polarity, vs_active,
                                active_vertical_source_out, 1'b0, sog_active, 1'b0};

   // ----------------------------------------
   // source selection
   // ----------------------------------------
   reg next_ahs;
   reg next_avs;

   always @* begin
      next_ahs = sync_mode[`MODE_H_SELECT];
      if (!sync_mode[`MODE_H_OVERRIDE] && hs_active && !sog_active) begin
         next_ahs = 1'b0;
      end else if (!sync_mode[`MODE_H_OVERRIDE] && !hs_active && sog_active) begin
         next_ahs = 1'b1;
      end // override keeps the select bit
      next_avs = sync_mode[`MODE_V_SELECT];
      if (!sync_mode[`MODE_V_OVERRIDE]) begin
         if (!vs_active && !sog_active) begin
            next_avs = 1'b1;
         end else if (vs_active && sog_active) begin
            next_avs = sync_mode[`MODE_V_SELECT];
         end else begin
            next_avs = sog_active;
         end
      end
   end

   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         active_horizontal_source_out <= 1'b0;
         active_vertical_source_out <= 1'b1;
      end else begin
         active_horizontal_source_out <= next_ahs;
         active_vertical_source_out <= next_avs;
      end
   end

   // ----------------------------------------
   // sync separator on the 5 MHz tick
   // ----------------------------------------
   reg [`SEP_DIV_W-1:0] tick_div;
   reg sep_tick;
   reg [7:0] sep_cnt;

   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         tick_div <= {`SEP_DIV_W{1'b0}};
         sep_tick <= 1'b0;
         sep_cnt <= 8'h00;
         sep_vsync_out <= 1'b0;
      end else begin
         sep_tick <= (tick_div == `SEP_DIV - 1);
         tick_div <= (tick_div == `SEP_DIV - 1) ? {`SEP_DIV_W{1'b0}} : tick_div + 1'b1;
         // is on software: threshold must exceed the line pulse width
         if (sync_on_green_input_in == sep_vsync_out) begin
            sep_cnt <= 8'h00;
         end else if (sep_tick) begin
            if (sep_cnt >= separator_threshold) begin
               sep_vsync_out <= sync_on_green_input_in;
               sep_cnt <= 8'h00;
            end else begin
               sep_cnt <= sep_cnt + 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // coast window
   // ----------------------------------------
   wire h_sel;
   wire v_sel;
   wire [`LINE_W:0] lead_sum;
   wire pre_window;
   reg h_sel_prev;
   reg v_sel_prev;
   reg [`LINE_W-1:0] line_cnt;
   reg [`LINE_W-1:0] frame_lines;
   reg [7:0] post_cnt;

   assign h_sel = active_horizontal_source_out ? sync_on_green_input_in : hsync_in;
   assign v_sel = active_vertical_source_out ? sep_vsync_out : vsync_in;
   assign lead_sum = {1'b0, line_cnt} + {{(`LINE_W - 7){1'b0}}, coast_lead_lines};
   // predicts the next vertical sync from the line count of the frame before
   assign pre_window = (frame_lines != {`LINE_W{1'b0}}) &&
                       (coast_lead_lines != 8'h00) &&
                       (lead_sum > {1'b0, frame_lines});

   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         h_sel_prev <= 1'b0;
         v_sel_prev <= 1'b0;
         line_cnt <= {`LINE_W{1'b0}};
         frame_lines <= {`LINE_W{1'b0}};
         post_cnt <= 8'h00;
         coast_out <= 1'b0;
      end else begin
         h_sel_prev <= h_sel;
         v_sel_prev <= v_sel;
         if (v_sel && !v_sel_prev) begin
            frame_lines <= line_cnt;
            line_cnt <= {`LINE_W{1'b0}};
         end else if (h_sel && !h_sel_prev && line_cnt != {`LINE_W{1'b1}}) begin
            line_cnt <= line_cnt + 1'b1;
         end
         if (!v_sel && v_sel_prev) begin
            post_cnt <= coast_trail_lines;
         end else if (h_sel && !h_sel_prev && post_cnt != 8'h00) begin
            post_cnt <= post_cnt - 1'b1;
         end
         coast_out <= pre_window || v_sel || (post_cnt != 8'h00);
      end
   end
endmodule // sync_processing_control

/* tb/sync_proc_checker_assertions.sv */
// checker for the sync control block: read back, overrides and separator filtering
// assumes it is bound to sync_processing_control and sees only its ports
module sync_proc_checker (
   // clock and reset
   input wire core_clk_in,
   input wire rstn_in,
   // register port
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire [7:0] reg_rdata_out,
   // sync and controls
   input wire sync_on_green_input_in,
   input wire [4:0] slicer_code_out,
   input wire red_clamp_mid_out,
   input wire blue_clamp_mid_out,
   input wire active_horizontal_source_out,
   input wire active_vertical_source_out,
   input wire sep_vsync_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);
   // ------
   // shadow of the writable registers
   // ------
   logic [7:0] shd [0:5];
   logic [1:0] quiet;
   wire [7:0] idx = reg_addr_in - 8'h0E;
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         shd <= '{8'h00, 8'h00, 8'h78, 8'h20, 8'h00, 8'h00};
         quiet <= 2'h0;
      end else begin
         quiet <= reg_wr_in ? 2'h0 : quiet + {1'h0, quiet != 2'h3};
         if (reg_wr_in && idx < 8'h06 && idx != 8'h01)
            shd[idx[2:0]] <= reg_wdata_in & (idx == 8'h00 ? 8'h1B : idx == 8'h02 ? 8'hFE : 8'hFF);
      end
   end
   AST_READ_BACK:
   assert property (quiet == 2'h3 && $past(idx) < 8'h06 |-> reg_rdata_out == shd[$past(idx[2:0])])
      else $error("read back differs from shadow");
   AST_STATUS_ZERO:
   assert property ($past(reg_addr_in) == 8'h14 |-> reg_rdata_out[2] == 1'h0 && !reg_rdata_out[0])
      else $error("status reserved bit set");
   AST_AHS_STATUS:
   assert property ($past(reg_addr_in) == 8'h14 |-> reg_rdata_out[6] == active_horizontal_source_out
      || reg_rdata_out[6] == $past(active_horizontal_source_out)) else $error("status bit 6 off");
   AST_AVS_STATUS:
   assert property ($past(reg_addr_in) == 8'h14 |-> reg_rdata_out[3] == active_vertical_source_out
      || reg_rdata_out[3] == $past(active_vertical_source_out)) else $error("status bit 3 off");
   AST_SLICER_CLAMP:
   assert property (quiet == 2'h3 |->
      {slicer_code_out, red_clamp_mid_out, blue_clamp_mid_out} == shd[2][7:1])
      else $error("slicer or clamp output off");
   AST_H_OVERRIDE:
   assert property (quiet == 2'h3 && shd[0][4] |-> active_horizontal_source_out == shd[0][3])
      else $error("horizontal override ignored");
   AST_V_OVERRIDE:
   assert property (quiet == 2'h3 && shd[0][1] |-> active_vertical_source_out == shd[0][0])
      else $error("vertical override ignored");
   AST_SEP_FILTER:
   assert property ($changed(sep_vsync_out) |-> $past(sync_on_green_input_in, 6) == sep_vsync_out
      && $past(sync_on_green_input_in, 9) == sep_vsync_out) else $error("separator flipped early");
   cover property ($fell(sep_vsync_out));
   cover property ($rose(active_horizontal_source_out));
   cover property ($fell(active_vertical_source_out));
endmodule // sync_proc_checker

bind sync_processing_control sync_proc_checker u_chk (
   .core_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rdata_out,
   .sync_on_green_input_in, .slicer_code_out, .red_clamp_mid_out, .blue_clamp_mid_out,
   .active_horizontal_source_out, .active_vertical_source_out, .sep_vsync_out);

/* tb/video_sync_source.sv */
// graphics source model: hsync, vsync and composite sync-on-green
// assumes the shared core clock; a line is 24 clocks and a frame 7 lines
module video_sync_source (
   // clock
   input wire core_clk_in,
   // enables and polarity
   input wire h_en_in,
   input wire v_en_in,
   input wire s_en_in,
   input wire h_neg_in,
   // sync pins
   output wire hsync_out,
   output wire vsync_out,
   output wire sog_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] px = 5'h00;
   logic [2:0] ln = 3'h0;
   // ------
   // line and frame timing
   // ------
   always @(posedge core_clk_in) begin
      px <= (px == 5'h17) ? 5'h00 : px + 5'h01;
      if (px == 5'h17)
         ln <= (ln == 3'h6) ? 3'h0 : ln + 3'h1;
   end
   // disabled lines stand static; sync-on-green is active low with a long vertical pulse
   assign hsync_out = (h_en_in & (px < 5'h04)) ^ h_neg_in;
   assign vsync_out = v_en_in & (ln == 3'h0);
   assign sog_out = ~(s_en_in & ((px < 5'h04) | (ln == 3'h0)));
endmodule // video_sync_source

/* tb/tb_sync_processing_control.sv */
// self-checking bench for the sync control block, driven through its register port
// assumes the source model and the bound checker are compiled before it
module tb_sync_processing_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'h0;
   logic rstn_in = 1'h0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'h0;
   logic [3:0] ctl = 4'h0;
   wire [7:0] reg_rdata_out;
   wire [4:0] slicer_code_out;
   wire red_clamp_mid_out, blue_clamp_mid_out, hsync_in, vsync_in, sync_on_green_input_in;
   wire active_horizontal_source_out, active_vertical_source_out, sep_vsync_out, coast_out;
   logic [31:0] t;
   int fails = 0;
   int n_tests = 0;
   int cc;
   int sc;
   // table: [27:24] neg/h/v/sog enables, [23:16] mode, [15:8] status, [7:0] mask
   localparam logic [31:0] SEL [0:9] = '{32'h0400A8FF, 32'h01004ADF, 32'h0500AAFF,
      32'h0508EAFF, 32'h0700B2FF, 32'h0701BAFF, 32'h0618F0FF, 32'h010242DF, 32'h0C0088FF,
      32'h000848DF};
   localparam logic [7:0] CFG [0:3] = '{8'hFF, 8'h00, 8'h04, 8'h02};
   always #20 core_clk_in = ~core_clk_in;
   sync_processing_control #(.ACT_TIMEOUT_CYCLES(20'h000C8)) DUT (
      .core_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rdata_out,
      .hsync_in, .vsync_in, .sync_on_green_input_in, .slicer_code_out, .red_clamp_mid_out,
      .blue_clamp_mid_out, .active_horizontal_source_out, .active_vertical_source_out,
      .sep_vsync_out, .coast_out);
   video_sync_source src (.core_clk_in, .h_neg_in(ctl[3]), .h_en_in(ctl[2]),
      .v_en_in(ctl[1]), .s_en_in(ctl[0]), .hsync_out(hsync_in), .vsync_out(vsync_in),
      .sog_out(sync_on_green_input_in));
   // ------
   // access and compare tasks
   // ------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'h1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'h0;
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
      n_tests++;
      if ((g & m) !== (e & m)) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      @(posedge core_clk_in);
      #1;
      chk8(reg_rdata_out, e, m);
   endtask
   task automatic rng(input int g, input int lo, input int hi);
      n_tests++;
      if (g < lo || g > hi) begin
         fails++;
         $display("unexpected at %0t: count %0d", $time, g);
      end
   endtask
   // one frame of coast high and separator low cycles
   task automatic meas;
      cc = 0;
      sc = 0;
      repeat (168) begin
         @(posedge core_clk_in);
         #1;
         cc += (coast_out === 1'h1);
         sc += (sep_vsync_out === 1'h0);
      end
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge core_clk_in);
      rstn_in <= 1'h1;
      repeat (260) @(posedge core_clk_in);
      rchk(8'h0E, 8'h00, 8'hFF);
      rchk(8'h10, 8'h78, 8'hFF);
      rchk(8'h11, 8'h20, 8'hFF);
      rchk(8'h12, 8'h00, 8'hFF);
      rchk(8'h13, 8'h00, 8'hFF);
      rchk(8'h0F, 8'h00, 8'hFF);
      rchk(8'h14, 8'h08, 8'hDF);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h10, CFG[i]);
         rchk(8'h10, CFG[i] & 8'hFE, 8'hFF);
         chk8({slicer_code_out, red_clamp_mid_out, blue_clamp_mid_out, 1'h0}, CFG[i],
            8'hFE);
      end
      wr(8'h0E, 8'hFF);
      rchk(8'h0E, 8'h1B, 8'hFF);
      wr(8'h14, 8'hFF);
      rchk(8'h14, 8'h48, 8'hDF);
      $display("test registers done");
      for (int i = 0; i < 10; i++) begin
         t = SEL[i];
         @(posedge core_clk_in);
         ctl <= t[27:24];
         wr(8'h0E, t[23:16]);
         repeat (260) @(posedge core_clk_in);
         rchk(8'h14, t[15:8], t[7:0]);
         chk8({6'h00, active_horizontal_source_out, active_vertical_source_out},
            {6'h00, t[14], t[11]}, 8'hFF);
      end
      $display("test source select done");
      @(posedge core_clk_in);
      ctl <= 4'h7;
      wr(8'h0E, 8'h00);
      repeat (400) @(posedge core_clk_in);
      meas;
      rng(sc, 0, 0);
      rng(cc, 24, 25);
      wr(8'h11, 8'h02);
      repeat (336) @(posedge core_clk_in);
      meas;
      rng(sc, 15, 40);
      wr(8'h13, 8'h02);
      repeat (336) @(posedge core_clk_in);
      meas;
      rng(cc, 48, 73);
      wr(8'h13, 8'h00);
      wr(8'h12, 8'h01);
      repeat (504) @(posedge core_clk_in);
      meas;
      rng(cc, 25, 49);
      $display("test separator and coast done");
      test_done;
   end
   initial begin
      repeat (20000) @(posedge core_clk_in);
      fails++;
      test_done;
   end
endmodule // tb_sync_processing_control
